// *** include/wds_consts.svh ***
// Constants for the wiper decrement sequencer
`ifndef WDS_CONSTS_SVH
`define WDS_CONSTS_SVH
// ----------------------------------------
// Register addresses
// ----------------------------------------
`define WDS_ADDR_WIPER0      4'h0
`define WDS_ADDR_WIPER1      4'h1
`define WDS_ADDR_WIPER2      4'h4
// ----------------------------------------
// Command byte fields
// ----------------------------------------
`define WDS_CMD_STEP_DOWN    2'h2
`define WDS_BITS_PER_CMD     4'h8
`define WDS_ERR_BIT_CNT      4'h6
// ----------------------------------------
// Wiper scale values
// ----------------------------------------
`define WDS_FULL_8BIT        9'h100
`define WDS_FULL_7BIT        9'h080
`define WDS_ZERO_SCALE       9'h000
`define WDS_WIPER_RESET_8BIT 9'h080
`define WDS_WIPER_RESET_7BIT 9'h040
`endif

// *** include/wds_pkg.sv ***
// Types for the wiper decrement sequencer
package wds_pkg;
    typedef logic [8:0] wds_wiper_t;
    typedef enum logic [1:0] {
        WDS_IDLE,
        WDS_SHIFT,
        WDS_ERROR
    } wds_state_t;
endpackage : wds_pkg

// *** verilog/wds_sync.sv ***
// Two-stage synchroniser for one level
`timescale 1ns/10ps
module wds_sync (
    input  wire logic clk,
    input  wire logic sys_rst,
    input  wire logic din,
    output logic      dout
);
    logic meta_r;
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            meta_r <= 1'b0;
            dout   <= 1'b0;
        end else begin
            meta_r <= din;
            dout   <= meta_r;
        end
    end
endmodule : wds_sync

// *** verilog/wds_top.sv ***
// Serial step-down command sequencer for three volatile wiper registers
// Behaviour
// RULE1: Step-down commands are taken only for wiper addresses 00h, 01h and 04h.
// RULE2: Each command in one frame acts on the wiper its own address selects.
// RULE3: Each accepted command lowers the selected wiper by exactly one.
// RULE4: Stepping down works from full scale, 100h for 8-bit and 80h for 7-bit.
// RULE5: A wiper above full scale is left unchanged by a step-down command.
// RULE6: A wiper at zero stays at zero and never wraps.
// RULE7: Commands repeat inside one frame with no chip-select release needed.
// RULE8: Any other valid command may follow a step-down in the same frame; here any command code other than step-down is refused as an error.
// RULE9: The wiper changes only after the eighth serial clock of the byte.
// RULE10: The host releases chip select promptly after the last wanted step.
// RULE11: The error flag is driven on serial data out at the seventh clock.
// RULE12: Only volatile addresses are valid; any other address is an error.
// RULE13: A byte is four address bits MSB first, two command bits, two spare bits.
`timescale 1ns/10ps
`include "wds_consts.svh"
module wds_top
    import wds_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        sys_rst,
    input  wire logic        eight_bit_part,
    input  wire logic        cs_n,
    input  wire logic        sck,
    input  wire logic        sdi,
    output logic             sdo_out,
    output logic             sdo_oe,
    output wds_wiper_t       wiper0,
    output wds_wiper_t       wiper1,
    output wds_wiper_t       wiper2,
    output logic             command_error_flag
);
    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    logic cs_n_s;
    logic cs_act_s;
    logic eight_s;
    logic sck_s;
    logic sdi_s;
    logic sck_d_r;
    // Select synchronised active high so that reset reads as deselected
    wds_sync u_cs  (.clk(clk), .sys_rst(sys_rst), .din(~cs_n), .dout(cs_act_s));
    wds_sync u_width (.clk(clk), .sys_rst(sys_rst), .din(eight_bit_part), .dout(eight_s));
    assign cs_n_s = ~cs_act_s;
    wds_sync u_sck (.clk(clk), .sys_rst(sys_rst), .din(sck),  .dout(sck_s));
    wds_sync u_sdi (.clk(clk), .sys_rst(sys_rst), .din(sdi),  .dout(sdi_s));

    logic sck_rise;
    logic sck_fall;
    assign sck_rise = sck_s & ~sck_d_r & ~cs_n_s;
    assign sck_fall = ~sck_s & sck_d_r & ~cs_n_s;

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            sck_d_r <= 1'b0;
        end else begin
            sck_d_r <= sck_s;
        end
    end

    // ----------------------------------------
    // Decode helpers
    // ----------------------------------------
    function automatic logic addr_valid(input logic [3:0] a);
        addr_valid = (a == `WDS_ADDR_WIPER0) || (a == `WDS_ADDR_WIPER1) ||
                     (a == `WDS_ADDR_WIPER2);
    endfunction : addr_valid

    function automatic wds_wiper_t step_down(input wds_wiper_t v, input logic eight);
        wds_wiper_t full;
        full = eight ? `WDS_FULL_8BIT : `WDS_FULL_7BIT;
        if (v > full || v == `WDS_ZERO_SCALE) begin
            step_down = v;
        end else begin
            step_down = v - 9'h001;
        end
    endfunction : step_down

    // ----------------------------------------
    // Frame state and bit counter
    // ----------------------------------------
    wds_state_t  state_r;
    logic [3:0]  bit_cnt_r;
    logic [7:0]  shift_r;
    logic [7:0]  byte_nxt;
    logic        byte_done;
    logic        eight_r;
    assign byte_nxt  = {shift_r[6:0], sdi_s};
    assign byte_done = sck_rise && (bit_cnt_r == `WDS_BITS_PER_CMD - 4'h1);

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_r   <= WDS_IDLE;
            bit_cnt_r <= 4'h0;
            shift_r   <= 8'h00;
        end else if (cs_n_s) begin
            state_r   <= WDS_IDLE;
            bit_cnt_r <= 4'h0;
        end else begin
            unique case (state_r)
                WDS_IDLE: begin
                    state_r <= WDS_SHIFT;
                end
                WDS_SHIFT: begin
                    if (sck_rise) begin
                        shift_r <= byte_nxt;
                        // Counter wraps so the next byte starts at once [RULE7]
                        bit_cnt_r <= byte_done ? 4'h0 : bit_cnt_r + 4'h1;
                        if (bit_cnt_r == `WDS_ERR_BIT_CNT - 4'h1 &&
                            !(addr_valid(byte_nxt[5:2]) &&
                              byte_nxt[1:0] == `WDS_CMD_STEP_DOWN)) begin
                            state_r <= WDS_ERROR; // [RULE12]
                        end
                    end
                end
                WDS_ERROR: begin
                    state_r <= WDS_ERROR;
                end
            endcase
        end
    end

    // ----------------------------------------
    // Part width strap caught whenever idle and deselected
    // ----------------------------------------
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            eight_r <= 1'b1;
        end else if (state_r == WDS_IDLE && cs_n_s) begin
            eight_r <= eight_s;
        end
    end

    // ----------------------------------------
    // Wiper update at the eighth clock
    // ----------------------------------------
    logic [3:0] cmd_addr;
    logic       cmd_ok;
    // Whole byte with the eighth bit, which is not yet in shift_r
    assign cmd_addr = byte_nxt[7:4];
    assign cmd_ok   = state_r == WDS_SHIFT && byte_nxt[3:2] == `WDS_CMD_STEP_DOWN; // [RULE13]

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            wiper0 <= `WDS_WIPER_RESET_8BIT;
            wiper1 <= `WDS_WIPER_RESET_8BIT;
            wiper2 <= `WDS_WIPER_RESET_8BIT;
        end else if (byte_done && cmd_ok) begin // [RULE9] [RULE8]
            unique case (cmd_addr) // [RULE1] [RULE2]
                `WDS_ADDR_WIPER0: wiper0 <= step_down(wiper0, eight_r); // [RULE3] [RULE4]
                `WDS_ADDR_WIPER1: wiper1 <= step_down(wiper1, eight_r); // [RULE5]
                `WDS_ADDR_WIPER2: wiper2 <= step_down(wiper2, eight_r); // [RULE6]
                default: begin
                end
            endcase
        end
    end

    // ----------------------------------------
    // Serial data out and error flag
    // ----------------------------------------
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            sdo_out            <= 1'b1;
            sdo_oe             <= 1'b0;
            command_error_flag <= 1'b0;
        end else if (cs_n_s) begin
            sdo_out            <= 1'b1;
            sdo_oe             <= 1'b0;
            command_error_flag <= 1'b0;
        end else if (sck_fall && bit_cnt_r == `WDS_ERR_BIT_CNT) begin
            // Open drain: pull low only to report an error [RULE11]
            sdo_out            <= 1'b0;
            sdo_oe             <= state_r == WDS_ERROR;
            command_error_flag <= state_r == WDS_ERROR;
        end else if (state_r == WDS_ERROR) begin
            sdo_oe             <= command_error_flag;
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    chk_zero_no_wrap: assert property (@(posedge clk) disable iff (sys_rst) // [RULE6]
        $past(wiper0) == 9'h000 |-> wiper0 == 9'h000)
        else $error("wiper0 wrapped below zero");
    chk_above_full: assert property (@(posedge clk) disable iff (sys_rst) // [RULE5]
        $past(wiper1) > 9'h100 |-> wiper1 == $past(wiper1))
        else $error("wiper1 changed above full scale");
    chk_single_step: assert property (@(posedge clk) disable iff (sys_rst) // [RULE3]
        wiper2 != $past(wiper2) |-> wiper2 == $past(wiper2) - 9'h001)
        else $error("wiper2 moved by more than one");
    chk_eighth_only: assert property (@(posedge clk) disable iff (sys_rst) // [RULE9]
        wiper0 != $past(wiper0) |-> $past(byte_done))
        else $error("wiper0 moved away from eighth clock");
    chk_frame_only: assert property (@(posedge clk) disable iff (sys_rst) // [RULE7]
        $past(cs_n_s) |-> wiper1 == $past(wiper1))
        else $error("wiper1 moved outside a frame");
    chk_err_sticky: assert property (@(posedge clk) disable iff (sys_rst) // [RULE12]
        state_r == WDS_ERROR && !cs_n_s |=> state_r == WDS_ERROR || cs_n_s)
        else $error("error state left inside frame");
    chk_err_drive: assert property (@(posedge clk) disable iff (sys_rst) // [RULE11]
        sdo_oe |-> state_r == WDS_ERROR && sdo_out == 1'b0)
        else $error("sdo driven without error");
    chk_no_drive_idle: assert property (@(posedge clk) disable iff (sys_rst) // [RULE11]
        ##1 $past(cs_n_s) |-> !sdo_oe)
        else $error("sdo driven while deselected");
    chk_frozen_in_error: assert property (@(posedge clk) disable iff (sys_rst) // [RULE12]
        state_r == WDS_ERROR |=> wiper0 == $past(wiper0) && wiper1 == $past(wiper1) &&
            wiper2 == $past(wiper2))
        else $error("wiper moved after a refused command");
    chk_flag_error_only: assert property (@(posedge clk) disable iff (sys_rst) // [RULE11]
        command_error_flag |-> state_r == WDS_ERROR)
        else $error("error flag raised for a good command");

    // Main scenarios
    cov_step: cover property (@(posedge clk) disable iff (sys_rst)
        wiper0 != $past(wiper0));
    cov_two: cover property (@(posedge clk) disable iff (sys_rst)
        byte_done && cmd_ok ##[1:200] byte_done && cmd_ok);
    cov_err: cover property (@(posedge clk) disable iff (sys_rst) sdo_oe);
    cov_clamp: cover property (@(posedge clk) disable iff (sys_rst)
        byte_done && cmd_ok && cmd_addr == `WDS_ADDR_WIPER2 && wiper2 == `WDS_ZERO_SCALE);
    cov_cut_frame: cover property (@(posedge clk) disable iff (sys_rst)
        $rose(cs_n_s) && bit_cnt_r != 4'h0);
endmodule : wds_top

// *** testbench/wds_host_model.sv ***
// Host side model that shifts step-down command bytes into the sequencer
`timescale 1ns/10ps
module wds_host_model (
    output logic      cs_n,
    output logic      sck,
    output logic      sdi,
    input  wire logic sdo_line
);
    initial begin
        cs_n = 1'b1;
        sck  = 1'b0;
        sdi  = 1'b0;
    end
    task automatic begin_frame();
        cs_n = 1'b0;
        #62.5;
    endtask : begin_frame
    // MSB first, sck idle low, sdo sampled inside the 7th clock
    task automatic send_bits(input logic [7:0] b, input int n, output logic sdo_seen);
        sdo_seen = 1'b1;
        for (int i = 0; i < n; i++) begin
            sdi = b[7 - i];
            #31.25 sck = 1'b1;
            #31.25 if (i == 6) sdo_seen = sdo_line;
            #31.25 sck = 1'b0;
            #31.25;
        end
    endtask : send_bits
    // Prompt release after the last byte; sdi no longer holds its value
    task automatic end_frame();
        cs_n = 1'b1;
        sdi  = ~sdi;
        #250;
    endtask : end_frame
endmodule : wds_host_model

// *** testbench/testbench.sv ***
// Self-checking bench for the wiper step-down sequencer
`timescale 1ns/10ps
`include "wds_consts.svh"
module testbench;
    import wds_pkg::*;
    logic       clk, sys_rst, eight_bit_part, cs_n, sck, sdi, sdo_oe;
    logic       command_error_flag, sdo_line, sdo_out, err;
    wds_wiper_t wiper0, wiper1, wiper2;
    int         mismatches, checks_done;
    logic [5:0] bad [5] = '{6'h0A, 6'h0E, 6'h3E, 6'h04, 6'h07};
    assign sdo_line = sdo_oe ? sdo_out : 1'b1;
    wds_top DUT (.clk(clk), .sys_rst(sys_rst), .eight_bit_part(eight_bit_part),
        .cs_n(cs_n), .sck(sck), .sdi(sdi), .sdo_out(sdo_out), .sdo_oe(sdo_oe), .wiper0(wiper0),
        .wiper1(wiper1), .wiper2(wiper2), .command_error_flag(command_error_flag));
    wds_host_model host (.cs_n(cs_n), .sck(sck), .sdi(sdi), .sdo_line(sdo_line));
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic check(input logic [8:0] seen, input logic [8:0] exp);
        checks_done++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask : check
    task automatic cmd(input logic [3:0] addr, input logic [1:0] code, input logic bad_cmd);
        host.send_bits({addr, code, 2'h3}, 8, err);
        check({8'h00, err}, {8'h00, ~bad_cmd});
    endtask : cmd
    task automatic close_out();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : close_out
    initial begin
        #400000;
        mismatches++;
        close_out();
    end
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        sys_rst = 1'b1;
        eight_bit_part = 1'b0;
        mismatches = 0;
        checks_done = 0;
        repeat (2) @(posedge clk);
        @(negedge clk) sys_rst = 1'b0;
        repeat (4) @(negedge clk);
        check(wiper0, `WDS_WIPER_RESET_8BIT);
        check(wiper2, `WDS_WIPER_RESET_8BIT);
        check({8'h00, sdo_oe | command_error_flag}, 9'h000);
        $display("test reset done");
        host.begin_frame();
        cmd(`WDS_ADDR_WIPER0, `WDS_CMD_STEP_DOWN, 1'b0);
        cmd(`WDS_ADDR_WIPER1, `WDS_CMD_STEP_DOWN, 1'b0);
        cmd(`WDS_ADDR_WIPER2, `WDS_CMD_STEP_DOWN, 1'b0);
        host.end_frame();
        check(wiper0, `WDS_FULL_7BIT - 9'h001);
        check(wiper1, `WDS_FULL_7BIT - 9'h001);
        check(wiper2, `WDS_FULL_7BIT - 9'h001);
        $display("test three targets done");
        @(negedge clk) eight_bit_part = 1'b1;
        repeat (4) @(negedge clk);
        host.begin_frame();
        host.send_bits({`WDS_ADDR_WIPER0, `WDS_CMD_STEP_DOWN, 2'h0}, 7, err);
        repeat (8) @(negedge clk);
        check(wiper0, 9'h07F);
        host.end_frame();
        check(wiper0, 9'h07F);
        host.begin_frame();
        cmd(`WDS_ADDR_WIPER0, `WDS_CMD_STEP_DOWN, 1'b0);
        check(wiper0, 9'h07E);
        cmd(`WDS_ADDR_WIPER0, `WDS_CMD_STEP_DOWN, 1'b0);
        host.end_frame();
        check(wiper0, 9'h07D);
        $display("test byte boundary done");
        host.begin_frame();
        for (int k = 0; k < 130; k++)
            cmd(`WDS_ADDR_WIPER2, `WDS_CMD_STEP_DOWN, 1'b0);
        host.end_frame();
        check(wiper2, `WDS_ZERO_SCALE);
        check(wiper1, 9'h07F);
        $display("test zero clamp done");
        for (int b = 0; b < 5; b++) begin
            host.begin_frame();
            cmd(bad[b][5:2], bad[b][1:0], 1'b1);
            cmd(`WDS_ADDR_WIPER1, `WDS_CMD_STEP_DOWN, 1'b1);
            check({8'h00, command_error_flag}, 9'h001);
            host.end_frame();
            check({8'h00, command_error_flag}, 9'h000);
            check(wiper1, 9'h07F);
        end
        $display("test refused commands done");
        close_out();
    end
endmodule : testbench
